// [hw/spd_pkg.sv]
// Purpose: Constants for the serial programming instruction decoder.
// Assumes: 50 MHz core clock, link clock sampled as an ordinary input.
// Notes:   Instruction codes, selectors and busy times live here.
// What this block does
// - Echo second enable byte during third byte.
// - Sample input on rise, shift out on fall.
// - AC 80 00 00 erases flash and EEPROM.
// - Erase leaves every flash and EEPROM location at FF.
// - Poll F0 returns busy in bit zero.
// - 4D latches third byte as extended address.
// - 48/40 load high/low page buffer byte.
// - C1 loads EEPROM page buffer byte.
// - 28/20 read high/low program word byte.
// - 50 00, 58 08, 50 08 read fuses.
// - 4C commits program page to flash.
// - C2 commits EEPROM page buffer.
// - AC A0/A8/A4 write low/high/extended fuse.
// - Fuse bit zero means programmed.
`default_nettype none
package spd_pkg;
    // Instruction first bytes
    localparam logic [7:0] OP_ENABLE  = 8'hac;  // Enable, erase, fuse write
    localparam logic [7:0] OP_POLL    = 8'hf0;
    localparam logic [7:0] OP_EXTADR  = 8'h4d;
    localparam logic [7:0] OP_LD_HI   = 8'h48;
    localparam logic [7:0] OP_LD_LO   = 8'h40;
    localparam logic [7:0] OP_LD_EE   = 8'hc1;
    localparam logic [7:0] OP_RD_HI   = 8'h28;
    localparam logic [7:0] OP_RD_LO   = 8'h20;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_FHI  = 8'h58;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_WR_EE   = 8'hc2;
    // Second byte selectors
    localparam logic [7:0] SEL_ENABLE = 8'h53;
    localparam logic [7:0] SEL_ERASE  = 8'h80;
    localparam logic [7:0] SEL_FLO    = 8'ha0;
    localparam logic [7:0] SEL_FHI    = 8'ha8;
    localparam logic [7:0] SEL_FEXT   = 8'ha4;
    localparam logic [7:0] SEL_RD_HX  = 8'h08;
    // Erased value and fuse reset (all unprogrammed)
    localparam logic [7:0] ERASED     = 8'hff;
    localparam logic [7:0] FUSE_RST   = 8'hff;
    // Busy times in microseconds
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned T_FLASH_US    = 4500;
    localparam int unsigned T_EEPROM_US   = 9000;
    localparam int unsigned T_ERASE_US    = 9000;
    localparam int unsigned T_FUSE_US     = 4500;
    localparam int unsigned CYC_FLASH     = T_FLASH_US * CLK_MHZ;
    localparam int unsigned CYC_EEPROM    = T_EEPROM_US * CLK_MHZ;
    localparam int unsigned CYC_ERASE     = T_ERASE_US * CLK_MHZ;
    localparam int unsigned CYC_FUSE      = T_FUSE_US * CLK_MHZ;
    localparam int unsigned BUSY_W        = 20;
    localparam int unsigned BITS_PER_INST = 32;
endpackage
`default_nettype wire

// [hw/spd_sync.sv]
// Purpose: Two flip-flop synchroniser for one pin.
// Assumes: Input is asynchronous to clk_i.
// Notes:   The first stage feeds only the second.
`default_nettype none
module spd_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Pin in, synchronised out
    input  wire logic pin_i,
    output logic      sync_o
);
    logic meta_q;  // First stage, read only by sync_o
    logic meta_d;
    logic sync_d;

    // Next values
    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_o <= sync_d;
        end
    end
endmodule
`default_nettype wire

// [hw/spd_busy.sv]
// Purpose: Busy timer for self-timed memory operations.
// Assumes: Start is a one-cycle pulse with the count loaded.
// Notes:   A new start while busy reloads the count.
`default_nettype none
module spd_busy #(
    parameter int unsigned W = 20
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         start_i,
    input  wire logic [W-1:0] cycles_i,
    output logic              busy_o
);
    logic [W-1:0] cnt_q;  // Cycles left
    logic [W-1:0] cnt_d;

    // Load on start, count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (start_i) begin
            cnt_d = cycles_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = (cnt_q != '0);
endmodule
`default_nettype wire

// [hw/spd_decoder.sv]
// Purpose: Serial programming instruction decoder with memory model.
// Assumes: Programmer holds device reset low (prog_rst_n_i) during a session.
// Notes:   Memories are flip-flop arrays; sizes are parameters.
//          Extended address is latched but not yet used at these sizes.
`default_nettype none
module spd_decoder
    import spd_pkg::*;
#(
    parameter int unsigned FLASH_AW  = 6,   // Word address bits of flash
    parameter int unsigned PAGE_AW   = 3,   // Word address bits within a page
    parameter int unsigned EE_AW     = 5,   // Byte address bits of EEPROM
    parameter int unsigned EE_PAW    = 2,   // Byte address bits within EEPROM page
    parameter int unsigned BUSY_FLASH = CYC_FLASH,
    parameter int unsigned BUSY_EE    = CYC_EEPROM,
    parameter int unsigned BUSY_ERASE = CYC_ERASE,
    parameter int unsigned BUSY_FUSE  = CYC_FUSE
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Serial link pins
    input  wire logic prog_rst_n_i,  // Device reset pin; programming only while low
    input  wire logic sck_i,
    input  wire logic mosi_i,
    output logic      miso_o,
    // Status
    output logic      prog_enabled_o,
    output logic      pending_operation_flag_o
);
    // Elaboration checks: address fields come from bytes two and three,
    // so no array may need more than sixteen address bits
    if (PAGE_AW > FLASH_AW || EE_PAW > EE_AW || FLASH_AW > 16 || EE_AW > 16) begin : g_chk
        $error("spd_decoder: address widths out of range");
    end
    // Busy spans must fit the timer's counter, or they would wrap short
    if (BUSY_FLASH >= (1 << BUSY_W) || BUSY_EE >= (1 << BUSY_W) ||
        BUSY_ERASE >= (1 << BUSY_W) || BUSY_FUSE >= (1 << BUSY_W)) begin : g_chk_busy
        $error("spd_decoder: busy span too long for timer");
    end

    localparam int unsigned FW = 1 << FLASH_AW;
    localparam int unsigned PW = 1 << PAGE_AW;
    localparam int unsigned EW = 1 << EE_AW;
    localparam int unsigned EP = 1 << EE_PAW;

    // Synchronised pins; all three share the same two-flop delay, so data
    // and clock keep their relative timing on the core side
    logic sck_s;   // Link clock level
    logic mosi_s;  // Link data level
    logic rstp_s;  // Device reset pin level, high ends the session
    spd_sync u_sck (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .pin_i  (sck_i),
        .sync_o (sck_s)
    );
    spd_sync u_mosi (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .pin_i  (mosi_i),
        .sync_o (mosi_s)
    );
    spd_sync u_rstp (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .pin_i  (prog_rst_n_i),
        .sync_o (rstp_s)
    );

    // Busy timer; a start while busy reloads it, the programmer polls first
    logic                busy;
    logic                busy_start;
    logic [BUSY_W-1:0]   busy_cyc;
    spd_busy #(.W(BUSY_W)) u_busy (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .start_i (busy_start),
        .cycles_i(busy_cyc),
        .busy_o  (busy)
    );

    // Link edge detect; the previous level resets low, the idle level of
    // the link clock, so no false edge follows reset
    logic sck_prev_q, sck_prev_d;
    logic rise, fall, link_rst;
    assign rise     = sck_s & ~sck_prev_q;
    assign fall     = ~sck_s & sck_prev_q;
    assign link_rst = rstp_s;  // Reset pin high: session over

    // Shifter state; the bit count wraps after 32, so frames need no marker
    logic [31:0] sh_q, sh_d;       // Received bits, MSB first
    logic [4:0]  cnt_q, cnt_d;     // Bits received in this instruction
    logic [7:0]  out_q, out_d;     // Byte being shifted out
    logic        miso_q, miso_d;
    logic        en_q, en_d;       // Programming enabled
    logic [7:0]  ext_q, ext_d;     // Extended address byte

    // Memories and fuses
    logic [7:0] flash_q [FW][2];
    logic [7:0] fpage_q [PW][2];
    logic [7:0] ee_q    [EW];
    logic [7:0] epage_q [EP];
    logic [EP-1:0] eload_q;        // EEPROM page bytes loaded
    logic [7:0] fuse_q  [3];       // Low, high, extended

    // Decode of the complete word. Fields come from the shifter with the
    // incoming bit appended, not from sh_d, so the next-value process
    // never reads its own output back through a loop
    logic [31:0] sh_in;            // Shifter as it will stand after a rise
    logic [7:0]  b1, b2, b3, b4;
    logic        done;             // Fourth byte just completed
    assign sh_in = {sh_q[30:0], mosi_s};
    assign b1    = sh_in[31:24];
    assign b2    = sh_in[23:16];
    assign b3    = sh_in[15:8];
    assign b4    = sh_in[7:0];
    assign done = rise && cnt_q == 5'd31 && !link_rst;

    logic [FLASH_AW-1:0] waddr;
    logic [EE_AW-1:0]    eaddr;
    assign waddr = FLASH_AW'({b2, b3});
    assign eaddr = EE_AW'({b2, b3});

    // Answer byte chosen when the third byte completes; only the rise
    // with a count of 23 uses it, when sh_in holds bytes one to three
    logic [7:0] third_out;
    always_comb begin
        third_out = 8'h00;
        case (sh_in[23:16])
            OP_POLL:    third_out = {7'h00, busy};
            OP_RD_HI:   third_out = flash_q[FLASH_AW'({sh_in[15:0]})][1];
            OP_RD_LO:   third_out = flash_q[FLASH_AW'({sh_in[15:0]})][0];
            OP_RD_FUSE: third_out = (sh_in[15:8] == 8'h00) ? fuse_q[0] : fuse_q[2];
            OP_RD_FHI:  third_out = (sh_in[15:8] == SEL_RD_HX) ? fuse_q[1] : 8'h00;
            default:    third_out = 8'h00;
        endcase
    end

    // Shift and control next values
    always_comb begin
        sh_d       = sh_q;
        cnt_d      = cnt_q;
        out_d      = out_q;
        miso_d     = miso_q;
        en_d       = en_q;
        ext_d      = ext_q;
        busy_start = 1'b0;
        busy_cyc   = '0;
        sck_prev_d = sck_s;
        if (link_rst) begin
            // Reset pin released: abandon session
            cnt_d = '0;
            en_d  = 1'b0;
            out_d = 8'h00;
        end else if (rise) begin
            sh_d  = sh_in;
            cnt_d = cnt_q + 5'd1;
            if (cnt_q == 5'd15) begin
                // Second byte in: prepare echo for third byte
                out_d = sh_in[7:0];
            end else if (cnt_q == 5'd23) begin
                out_d = third_out;
            end
            if (done && b1 == OP_ENABLE && b2 == SEL_ENABLE) begin
                en_d = 1'b1;
            end
            if (done && en_q && b1 == OP_EXTADR) begin
                ext_d = b3;
            end
            if (done && en_q && b1 == OP_ENABLE) begin
                if (b2 == SEL_ERASE && b3 == 8'h00 && b4 == 8'h00) begin
                    busy_start = 1'b1;
                    busy_cyc   = BUSY_W'(BUSY_ERASE);
                end else if (b2 == SEL_FLO || b2 == SEL_FHI || b2 == SEL_FEXT) begin
                    busy_start = 1'b1;
                    busy_cyc   = BUSY_W'(BUSY_FUSE);
                end
            end
            if (done && en_q && b1 == OP_WR_PAGE) begin
                busy_start = 1'b1;
                busy_cyc   = BUSY_W'(BUSY_FLASH);
            end
            if (done && en_q && b1 == OP_WR_EE) begin
                busy_start = 1'b1;
                busy_cyc   = BUSY_W'(BUSY_EE);
            end
        end else if (fall) begin
            // Read data leaves on the falling edge
            // One bit per fall; after the fourth byte the register is empty
            if (cnt_q[2:0] == 3'd0) begin
                miso_d = out_q[7];
                out_d  = {out_q[6:0], 1'b0};
            end else begin
                miso_d = out_q[7];
                out_d  = {out_q[6:0], 1'b0};
            end
        end
    end

    // Control registers; reset is synchronous here as in every process
    // of the block, so a short glitch on the reset net is filtered
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sh_q       <= '0;
            cnt_q      <= '0;
            out_q      <= 8'h00;
            miso_q     <= 1'b0;
            en_q       <= 1'b0;
            ext_q      <= 8'h00;
            sck_prev_q <= 1'b0;
        end else begin
            sh_q       <= sh_d;
            cnt_q      <= cnt_d;
            out_q      <= out_d;
            miso_q     <= miso_d;
            en_q       <= en_d;
            ext_q      <= ext_d;
            sck_prev_q <= sck_prev_d;
        end
    end

    // Memory writes; fuses keep one for unprogrammed bits.
    // A chip erase leaves the page buffers alone: a page write right after
    // an erase, with no fresh loads, writes their old contents back.
    logic act;
    assign act = done && en_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 3; i++) begin
                fuse_q[i] <= FUSE_RST;
            end
            for (int i = 0; i < FW; i++) begin
                flash_q[i][0] <= ERASED;
                flash_q[i][1] <= ERASED;
            end
            for (int i = 0; i < PW; i++) begin
                fpage_q[i][0] <= ERASED;
                fpage_q[i][1] <= ERASED;
            end
            for (int i = 0; i < EW; i++) begin
                ee_q[i] <= ERASED;
            end
            for (int i = 0; i < EP; i++) begin
                epage_q[i] <= ERASED;
            end
            eload_q <= '0;
        end else if (act) begin
            case (b1)
                OP_LD_HI: fpage_q[PAGE_AW'(b3)][1] <= b4;
                OP_LD_LO: fpage_q[PAGE_AW'(b3)][0] <= b4;
                OP_LD_EE: begin
                    epage_q[EE_PAW'(b3)] <= b4;
                    eload_q[EE_PAW'(b3)] <= 1'b1;
                end
                OP_WR_PAGE: begin
                    for (int i = 0; i < PW; i++) begin
                        flash_q[{waddr[FLASH_AW-1:PAGE_AW], PAGE_AW'(i)}][0] <= fpage_q[i][0];
                        flash_q[{waddr[FLASH_AW-1:PAGE_AW], PAGE_AW'(i)}][1] <= fpage_q[i][1];
                    end
                end
                OP_WR_EE: begin
                    for (int i = 0; i < EP; i++) begin
                        if (eload_q[i]) begin
                            ee_q[{eaddr[EE_AW-1:EE_PAW], EE_PAW'(i)}] <= epage_q[i];
                        end
                    end
                    eload_q <= '0;
                end
                OP_ENABLE: begin
                    if (b2 == SEL_ERASE && b3 == 8'h00 && b4 == 8'h00) begin
                        for (int i = 0; i < FW; i++) begin
                            flash_q[i][0] <= ERASED;
                            flash_q[i][1] <= ERASED;
                        end
                        for (int i = 0; i < EW; i++) begin
                            ee_q[i] <= ERASED;
                        end
                    end else if (b2 == SEL_FLO) begin
                        fuse_q[0] <= b4;
                    end else if (b2 == SEL_FHI) begin
                        fuse_q[1] <= b4;
                    end else if (b2 == SEL_FEXT) begin
                        fuse_q[2] <= b4;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Outputs; the pending flag is decoded from the timer's count register,
    // so it cannot pulse while the count is loaded
    assign miso_o                   = miso_q;
    assign prog_enabled_o           = en_q;
    assign pending_operation_flag_o = busy;
endmodule
`default_nettype wire

// [dv/spd_decoder_chk.sv]
// Purpose: Port assertions for the serial instruction decoder.
// Assumes: Link pins cross two sync flops before the decoder uses them.
// Notes:   Windows allow the sync delay plus one output register.
`default_nettype none
module spd_decoder_chk #(
    parameter int unsigned BUSY_FLASH = 20,
    parameter int unsigned BUSY_EE    = 20,
    parameter int unsigned BUSY_ERASE = 20,
    parameter int unsigned BUSY_FUSE  = 20
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link pins and status
    input wire logic prog_rst_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_o,
    input wire logic prog_enabled_o,
    input wire logic pending_operation_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Loose ceiling: sum of all busy spans covers any reload
    localparam int unsigned MAXB = BUSY_FLASH + BUSY_EE + BUSY_ERASE + BUSY_FUSE;
    logic        sck_q,  sck_d;   // Last link clock level
    logic [3:0]  fall_q, fall_d;  // Cycles since link clock fell
    logic [3:0]  rise_q, rise_d;  // Cycles since link clock rose
    logic [3:0]  hi_q,   hi_d;    // Cycles since device reset pin was high
    logic [31:0] pend_q, pend_d;  // Length of the current busy span
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Ages saturate at 15 so they never wrap into a false match
    always_comb begin
        sck_d  = sck_i;
        fall_d = (sck_q && !sck_i) ? 4'h0 : fall_q + 4'(fall_q != 4'hf);
        rise_d = (!sck_q && sck_i) ? 4'h0 : rise_q + 4'(rise_q != 4'hf);
        hi_d   = prog_rst_n_i ? 4'h0 : hi_q + 4'(hi_q != 4'hf);
        pend_d = pending_operation_flag_o ? pend_q + 32'h1 : 32'h0;
        if (!rst_n_i) begin
            fall_d = 4'hf;
            rise_d = 4'hf;
            hi_d   = 4'hf;
            pend_d = 32'h0;
        end
    end
    // Register only
    always_ff @(posedge clk_i) begin
        sck_q  <= sck_d;
        fall_q <= fall_d;
        rise_q <= rise_d;
        hi_q   <= hi_d;
        pend_q <= pend_d;
    end
    AST_RST_QUIET: assert property ($rose(rst_n_i) |-> !prog_enabled_o && !pending_operation_flag_o && !miso_o)
        else $error("outputs not quiet after reset");
    AST_MISO_ON_FALL: assert property ($changed(miso_o) && !prog_rst_n_i |-> fall_q <= 4'h6)
        else $error("serial output moved away from a falling link clock");
    AST_EN_NEEDS_LINK: assert property (prog_rst_n_i [*8] |-> !prog_enabled_o)
        else $error("enabled while device reset pin high");
    AST_EN_FALL: assert property ($fell(prog_enabled_o) |-> hi_q <= 4'h6)
        else $error("enable lost without device reset pulse");
    AST_EN_ON_RISE: assert property ($rose(prog_enabled_o) |-> rise_q <= 4'h8 && !prog_rst_n_i)
        else $error("enable not tied to a rising link clock");
    AST_PEND_START: assert property ($rose(pending_operation_flag_o) |-> rise_q <= 4'h8 && prog_enabled_o)
        else $error("busy started without a decoded instruction");
    AST_PEND_HOLDS: assert property ($rose(pending_operation_flag_o) |=> pending_operation_flag_o [*8])
        else $error("busy flag dropped at once");
    AST_PEND_BOUND: assert property (pending_operation_flag_o |-> pend_q <= MAXB)
        else $error("busy flag stuck");
    COV_ENABLED: cover property ($rose(prog_enabled_o));
    COV_BUSY_DONE: cover property ($fell(pending_operation_flag_o));
    COV_MISO_MOVES: cover property ($changed(miso_o));
endmodule
bind spd_decoder spd_decoder_chk #(
    .BUSY_FLASH(BUSY_FLASH), .BUSY_EE(BUSY_EE), .BUSY_ERASE(BUSY_ERASE), .BUSY_FUSE(BUSY_FUSE)
) u_chk (.clk_i, .rst_n_i, .prog_rst_n_i, .sck_i, .mosi_i, .miso_o, .prog_enabled_o, .pending_operation_flag_o);
`default_nettype wire

// [dv/spd_prog_model.sv]
// Purpose: In-system programmer acting as link master.
// Assumes: Caller enters each task just after a rising clock edge.
// Notes:   Link clock is 8 core clocks a period and stands low between frames.
`default_nettype none
module spd_prog_model
    import spd_pkg::*;
(
    // Core clock
    input  wire logic clk_i,
    // Link pins toward the device
    output var logic  prog_rst_n_o,
    output var logic  sck_o,
    output var logic  mosi_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device held out of programming until the first restart
    initial begin
        prog_rst_n_o = 1'b1;
        sck_o        = 1'b0;
        mosi_o       = 1'b0;
    end
    // One frame, MSB first; reply bits read late in the high phase
    task automatic xfer(input logic [31:0] ins, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi_o <= ins[i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx[i] = miso_i;
            sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        // Idle data line carries no stale bit
        mosi_o <= ~mosi_o;
        @(posedge clk_i);
    endtask
    // Positive reset pulse, then hold reset low for the session
    task automatic restart();
        prog_rst_n_o <= 1'b1;
        // Long enough for the enable to drop well before the pulse ends
        repeat (10) @(posedge clk_i);
        prog_rst_n_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
    // Enable; on a missing echo pulse reset and try once more
    task automatic enable(output logic [7:0] echo);
        logic [31:0] rx;
        for (int t = 0; t < 2; t++) begin
            xfer({OP_ENABLE, SEL_ENABLE, 16'h0000}, rx);
            echo = rx[15:8];
            if (echo === SEL_ENABLE) break;
            restart();
        end
    endtask
    // Poll until the pending bit clears; report whether it was seen set
    task automatic poll(output logic seen, output logic clear);
        logic [31:0] rx;
        seen  = 1'b0;
        clear = 1'b0;
        for (int n = 0; n < 40 && !clear; n++) begin
            xfer({OP_POLL, 24'h000000}, rx);
            seen  = seen | rx[0];
            clear = (rx[0] === 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// [dv/serial_program_cmd_decoder_bench.sv]
// Purpose: Self-checking bench for the instruction decoder.
// Assumes: Busy spans shortened to a few hundred core clocks.
// Notes:   Expected values come from the instruction table only.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module serial_program_cmd_decoder_bench;
    import spd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_n_i;         // Core clock and reset
    logic        prog_rst_n, sck, mosi;  // Driven by the programmer
    logic        miso, en, pend;         // Seen from the decoder
    logic [31:0] rx;                     // Last reply frame
    logic        seen, clr;              // Poll outcome
    int          mismatches, samples_checked;
    spd_decoder #(.BUSY_FLASH(600), .BUSY_EE(700), .BUSY_ERASE(900), .BUSY_FUSE(500)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .prog_rst_n_i(prog_rst_n), .sck_i(sck), .mosi_i(mosi),
        .miso_o(miso), .prog_enabled_o(en), .pending_operation_flag_o(pend));
    spd_prog_model prog (.clk_i(clk_i), .prog_rst_n_o(prog_rst_n), .sck_o(sck), .mosi_o(mosi), .miso_i(miso));
    always #10 clk_i = ~clk_i;
    // Send one four-byte instruction
    task automatic cmd(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
        prog.xfer({b1, b2, b3, b4}, rx);
    endtask
    // Busy must be seen set, then clear within the poll budget
    task automatic wait_done(input string nm);
        prog.poll(seen, clr);
        `CHK(nm, 2'b11, {seen, clr})
    endtask
    // Flash reads: two page words and one word of the other page
    task automatic rd_flash(input logic erased);
        logic [23:0] t[5] = '{{OP_RD_LO, 8'h0d, 8'h34}, {OP_RD_HI, 8'h0d, 8'h12},
            {OP_RD_LO, 8'h0f, 8'h78}, {OP_RD_HI, 8'h0f, 8'h9a}, {OP_RD_LO, 8'h05, 8'hff}};
        for (int i = 0; i < 5; i++) begin
            cmd(t[i][23:16], 8'h00, t[i][15:8], 8'h00);
            `CHK("flash_rd", erased ? ERASED : t[i][7:0], rx[7:0])
        end
    endtask
    // Before enabling, a fuse write is ignored
    task automatic t_locked();
        cmd(OP_ENABLE, SEL_FLO, 8'h00, 8'h00);
        `CHK("en_locked", 1'b0, en)
        `CHK("pend_locked", 1'b0, pend)
    endtask
    // Echo of the second byte, then enabled
    task automatic t_enable();
        logic [7:0] echo;
        prog.enable(echo);
        `CHK("echo", SEL_ENABLE, echo)
        `CHK("enabled", 1'b1, en)
    endtask
    // Fuses read unprogrammed, then each selector written and read back
    task automatic t_fuse();
        logic [7:0]  ws[3] = '{SEL_FLO, SEL_FHI, SEL_FEXT};
        logic [15:0] rs[3] = '{{OP_RD_FUSE, 8'h00}, {OP_RD_FHI, SEL_RD_HX}, {OP_RD_FUSE, SEL_RD_HX}};
        logic [7:0]  wv[3] = '{8'he2, 8'hd9, 8'hfe};
        for (int i = 0; i < 3; i++) begin
            cmd(rs[i][15:8], rs[i][7:0], 8'h00, 8'h00);
            `CHK("fuse_rst", FUSE_RST, rx[7:0])
        end
        for (int i = 0; i < 3; i++) begin
            cmd(OP_ENABLE, ws[i], 8'h00, wv[i]);
            wait_done("fuse_busy");
        end
        for (int i = 0; i < 3; i++) begin
            cmd(rs[i][15:8], rs[i][7:0], 8'h00, 8'h00);
            `CHK("fuse_rd", wv[i], rx[7:0])
        end
    endtask
    // Page load low before high, commit to page one, read back
    task automatic t_flash();
        cmd(OP_EXTADR, 8'h00, 8'h00, 8'h00);
        cmd(OP_LD_LO, 8'h00, 8'h05, 8'h34);
        cmd(OP_LD_HI, 8'h00, 8'h05, 8'h12);
        cmd(OP_LD_LO, 8'h00, 8'h07, 8'h78);
        cmd(OP_LD_HI, 8'h00, 8'h07, 8'h9a);
        `CHK("load_idle", 1'b0, pend)
        cmd(OP_WR_PAGE, 8'h00, 8'h08, 8'h00);
        wait_done("page_busy");
        rd_flash(1'b0);
    endtask
    // EEPROM buffer load then page commit
    task automatic t_eeprom();
        cmd(OP_LD_EE, 8'h00, 8'h01, 8'h5a);
        cmd(OP_WR_EE, 8'h00, 8'h04, 8'h00);
        wait_done("ee_busy");
    endtask
    // Chip erase returns flash to the erased value
    task automatic t_erase();
        cmd(OP_ENABLE, SEL_ERASE, 8'h00, 8'h00);
        wait_done("erase_busy");
        rd_flash(1'b1);
    endtask
    // Reset pulse drops the enable; a new enable restores it
    task automatic t_relink();
        prog.restart();
        `CHK("en_cleared", 1'b0, en)
        t_enable();
    endtask
    // Single exit point for pass, fail and watchdog
    task automatic results();
        $display("compared %0d, mismatched %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        clk_i   = 1'b0;
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        prog.restart();
        t_locked();
        t_enable();
        t_fuse();
        t_flash();
        t_eeprom();
        t_erase();
        t_relink();
        results();
    end
    // Watchdog: run needs about 0.26 ms
    initial begin
        #1000000;
        mismatches++;
        results();
    end
endmodule
`undef CHK
`default_nettype wire
